// [common/gex_pkg.sv]
// Shared constants for the 8-bit serial-bus port expander register logic.
// Assumes one 50 MHz core clock; all offsets are command-byte codes.
package gex_pkg;

  // ----------------------------------------------------------------
  // Clock and serial address
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;          // Core clock rate
  localparam logic [5:0] SLV_ADDR_HI = 6'h10;  // Fixed upper address bits 010000

  // ----------------------------------------------------------------
  // Command codes (register offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PIN_LEVEL_SAMPLE = 8'h00;
  localparam logic [7:0] OFS_PIN_DRIVE_VALUE = 8'h01;
  localparam logic [7:0] OFS_INPUT_INVERT_SELECT = 8'h02;
  localparam logic [7:0] OFS_PIN_DIRECTION = 8'h03;
  localparam logic [7:0] OFS_DRIVE_LEVEL_LOW_PINS = 8'h40;
  localparam logic [7:0] OFS_DRIVE_LEVEL_HIGH_PINS = 8'h41;
  localparam logic [7:0] OFS_INPUT_CAPTURE_ENABLE = 8'h42;
  localparam logic [7:0] OFS_BIAS_RESISTOR_ENABLE = 8'h43;
  localparam logic [7:0] OFS_BIAS_DIRECTION_SELECT = 8'h44;
  localparam logic [7:0] OFS_IRQ_SOURCE_MASK = 8'h45;
  localparam logic [7:0] OFS_IRQ_SOURCE_FLAGS = 8'h46;
  localparam logic [7:0] OFS_OUTPUT_STAGE_TYPE = 8'h4f;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PIN_DRIVE_VALUE = 8'hff;
  localparam logic [7:0] RST_INPUT_INVERT_SELECT = 8'h00;
  localparam logic [7:0] RST_PIN_DIRECTION = 8'hff;
  localparam logic [7:0] RST_DRIVE_LEVEL = 8'hff;
  localparam logic [7:0] RST_INPUT_CAPTURE_ENABLE = 8'h00;
  localparam logic [7:0] RST_BIAS_RESISTOR_ENABLE = 8'h00;
  localparam logic [7:0] RST_BIAS_DIRECTION_SELECT = 8'hff;
  localparam logic [7:0] RST_IRQ_SOURCE_MASK = 8'hff;
  localparam logic [7:0] RST_OUTPUT_STAGE_TYPE = 8'h00;
  localparam logic [7:0] RST_POINTER = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STAGE_OPEN_DRAIN_BIT = 0;     // Only live bit of output stage type

  // Serial engine states
  typedef enum logic [3:0] {
    GEX_IDLE, GEX_ADDR, GEX_ADDR_ACK, GEX_CMD, GEX_CMD_ACK,
    GEX_WDATA, GEX_WDATA_ACK, GEX_RDATA, GEX_RDATA_ACK
  } gex_state_t;

endpackage : gex_pkg

// [verilog/gex_expander.sv]
// Register, port and serial-slave logic of an 8-bit port expander.
// Assumes SCL, SDA, address, reset pin and port pins are asynchronous to ref_clk
// and that SCL is slow enough (period >= 8 ref_clk cycles) to be oversampled.
//
// Notes on behaviour
// - Address byte LSB: 1 read, 0 write
// - One address bit comes from address-select pin
// - Command byte after address loads the pointer
// - Pointer is write only, loaded by command
// - Decode 00h-03h and 40h-46h, 4Fh
// - Input sample shows pin levels, any direction
// - Input sample read only, writes ignored
// - Drive value only drives outputs, reads back written
// - Invert bit flips reported input pin level
// - Direction 1 input, 0 output; inputs after reset
// - Two-bit drive field per pin, two registers
// - Drive code quarter steps, reset full strength
// - Capture bit only acts on input pins
// - Non-latched change interrupts; read or return clears
// - Latched change interrupts and captures value
// - Latched return keeps interrupt and captured value
// - After captured read, next read shows pin
// - Mixed change: latched change reported, read clears
// - Leaving latched mode keeps pending interrupt
// - Read source follows current latch setting
// - Masked change never asserts interrupt; mask resets 1
// - Interrupt cleared at read acknowledge after SCL rise
module gex_expander #(
  parameter int PORT_W = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic resetPinN,
  input wire logic addrSelPin,
  input wire logic sclPin,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [PORT_W-1:0] portIn,
  output logic [PORT_W-1:0] portOut,
  output logic [PORT_W-1:0] portOe,
  output logic [2*PORT_W-1:0] driveLevel,
  output logic [PORT_W-1:0] biasEnable,
  output logic [PORT_W-1:0] biasPullUp,
  output logic intOut,
  output logic intOe
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rstPinSync_r;          // Reset pin, first stage read only by second
  logic [1:0] addrSync_r;            // Address-select pin
  logic [1:0] sclSync_r;             // Serial clock
  logic [1:0] sdaSync_r;             // Serial data
  logic [PORT_W-1:0] pinMeta_r;      // Port pins, first stage
  logic [PORT_W-1:0] pinLvl_r;       // Port pins, stable sample
  logic sclPrev_r;                   // Delayed SCL for edge finding
  logic sdaPrev_r;                   // Delayed SDA for start/stop finding
  logic rst;                         // Combined core reset

  // Two flops on every foreign input; only sys_rst clears them
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rstPinSync_r <= 2'h3;
      addrSync_r <= 2'h0;
      sclSync_r <= 2'h3;
      sdaSync_r <= 2'h3;
      pinMeta_r <= '0;
      pinLvl_r <= '0;
    end else begin
      rstPinSync_r <= {rstPinSync_r[0], resetPinN};
      addrSync_r <= {addrSync_r[0], addrSelPin};
      sclSync_r <= {sclSync_r[0], sclPin};
      sdaSync_r <= {sdaSync_r[0], sdaIn};
      pinMeta_r <= portIn;
      pinLvl_r <= pinMeta_r;
    end
  end

  // Reset pin acts like power-on reset on everything but the synchronisers
  assign rst = sys_rst | ~rstPinSync_r[1];

  // Edge history on the synchronised bus lines
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= sclSync_r[1];
      sdaPrev_r <= sdaSync_r[1];
    end
  end

  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  assign sclRise = sclSync_r[1] & ~sclPrev_r;
  assign sclFall = ~sclSync_r[1] & sclPrev_r;
  assign startSeen = sclSync_r[1] & sclPrev_r & sdaPrev_r & ~sdaSync_r[1];
  assign stopSeen = sclSync_r[1] & sclPrev_r & ~sdaPrev_r & sdaSync_r[1];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] cmdTarget_r;           // Pointer, never readable
  logic [PORT_W-1:0] driveValue_r;
  logic [PORT_W-1:0] invertSel_r;
  logic [PORT_W-1:0] direction_r;
  logic [PORT_W-1:0] driveLo_r;
  logic [PORT_W-1:0] driveHi_r;
  logic [PORT_W-1:0] captureEn_r;
  logic [PORT_W-1:0] biasEn_r;
  logic [PORT_W-1:0] biasDir_r;
  logic [PORT_W-1:0] irqMask_r;
  logic stageOd_r;                   // Open-drain select for the whole port

  // Serial engine state
  gex_pkg::gex_state_t state_r;
  logic [2:0] bitCnt_r;              // Bits done in current byte
  logic [7:0] rxShift_r;             // Incoming byte
  logic [7:0] txShift_r;             // Outgoing byte
  logic isRead_r;                    // Direction bit of current transfer
  logic wrStrobe;                    // One-cycle write of rxShift_r
  logic sampleReadAck;               // Input sample read acknowledged
  logic byteDone_r;                  // Eighth bit of the byte taken; count alone cannot tell start from full

  // ----------------------------------------------------------------
  // Change detection and capture
  // ----------------------------------------------------------------
  logic [PORT_W-1:0] refLvl_r;       // Level at last clear, the "original" level
  logic [PORT_W-1:0] capPend_r;      // Latched change pending
  logic [PORT_W-1:0] capVal_r;       // Captured level of a latched change
  logic [PORT_W-1:0] diffNow;
  logic [PORT_W-1:0] liveChange;
  logic [PORT_W-1:0] rawSource;
  logic [PORT_W-1:0] srcFlags;

  always_comb begin
    diffNow = (pinLvl_r ^ refLvl_r) & direction_r;
    // Non-latched source vanishes when the pin returns
    liveChange = diffNow & ~captureEn_r;
    // Pending latched change survives a later mode change
    rawSource = liveChange | capPend_r;
    srcFlags = rawSource & ~irqMask_r;
  end

  // Captured changes; in the ack cycle the clear wins and the pin becomes the new baseline
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      capPend_r <= '0;
      capVal_r <= '0;
      refLvl_r <= '0;
    end else begin
      for (int i = 0; i < PORT_W; i++) begin
        if (sampleReadAck) begin
          // Clear, then re-arm from the present level
          capPend_r[i] <= 1'b0;
          refLvl_r[i] <= pinLvl_r[i];
        end else if (!direction_r[i]) begin
          // Outputs cannot interrupt; follow the pin
          refLvl_r[i] <= pinLvl_r[i];
        end
        if (diffNow[i] && captureEn_r[i] && !capPend_r[i] && !sampleReadAck) begin
          capPend_r[i] <= 1'b1;
          capVal_r[i] <= pinLvl_r[i];
        end
      end
    end
  end

  // Input sample value: captured level only while latched and pending
  logic [PORT_W-1:0] sampleView;
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      sampleView[i] = (captureEn_r[i] & capPend_r[i] & direction_r[i]) ? capVal_r[i] : pinLvl_r[i];
      sampleView[i] = sampleView[i] ^ (invertSel_r[i] & direction_r[i]);
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] readMux(input logic [7:0] ptr, input logic [7:0] smp,
                                          input logic [7:0] flg);
    unique case (ptr)
      gex_pkg::OFS_PIN_LEVEL_SAMPLE: readMux = smp;
      gex_pkg::OFS_PIN_DRIVE_VALUE: readMux = driveValue_r;
      gex_pkg::OFS_INPUT_INVERT_SELECT: readMux = invertSel_r;
      gex_pkg::OFS_PIN_DIRECTION: readMux = direction_r;
      gex_pkg::OFS_DRIVE_LEVEL_LOW_PINS: readMux = driveLo_r;
      gex_pkg::OFS_DRIVE_LEVEL_HIGH_PINS: readMux = driveHi_r;
      gex_pkg::OFS_INPUT_CAPTURE_ENABLE: readMux = captureEn_r;
      gex_pkg::OFS_BIAS_RESISTOR_ENABLE: readMux = biasEn_r;
      gex_pkg::OFS_BIAS_DIRECTION_SELECT: readMux = biasDir_r;
      gex_pkg::OFS_IRQ_SOURCE_MASK: readMux = irqMask_r;
      gex_pkg::OFS_IRQ_SOURCE_FLAGS: readMux = flg;
      gex_pkg::OFS_OUTPUT_STAGE_TYPE: readMux = {7'h00, stageOd_r};
      default: readMux = 8'h00;
    endcase
  endfunction : readMux

  // Byte offered to a read, taken from the pointer at the moment of the fetch
  logic [7:0] rdByte;
  assign rdByte = readMux(cmdTarget_r, sampleView, srcFlags);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Only the data byte of a write transfer lands here
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      driveValue_r <= gex_pkg::RST_PIN_DRIVE_VALUE;
      invertSel_r <= gex_pkg::RST_INPUT_INVERT_SELECT;
      direction_r <= gex_pkg::RST_PIN_DIRECTION;
      driveLo_r <= gex_pkg::RST_DRIVE_LEVEL;
      driveHi_r <= gex_pkg::RST_DRIVE_LEVEL;
      captureEn_r <= gex_pkg::RST_INPUT_CAPTURE_ENABLE;
      biasEn_r <= gex_pkg::RST_BIAS_RESISTOR_ENABLE;
      biasDir_r <= gex_pkg::RST_BIAS_DIRECTION_SELECT;
      irqMask_r <= gex_pkg::RST_IRQ_SOURCE_MASK;
      stageOd_r <= gex_pkg::RST_OUTPUT_STAGE_TYPE[gex_pkg::STAGE_OPEN_DRAIN_BIT];
    end else if (wrStrobe) begin
      unique case (cmdTarget_r)
        gex_pkg::OFS_PIN_DRIVE_VALUE: driveValue_r <= rxShift_r;
        gex_pkg::OFS_INPUT_INVERT_SELECT: invertSel_r <= rxShift_r;
        gex_pkg::OFS_PIN_DIRECTION: direction_r <= rxShift_r;
        gex_pkg::OFS_DRIVE_LEVEL_LOW_PINS: driveLo_r <= rxShift_r;
        gex_pkg::OFS_DRIVE_LEVEL_HIGH_PINS: driveHi_r <= rxShift_r;
        gex_pkg::OFS_INPUT_CAPTURE_ENABLE: captureEn_r <= rxShift_r;
        gex_pkg::OFS_BIAS_RESISTOR_ENABLE: biasEn_r <= rxShift_r;
        gex_pkg::OFS_BIAS_DIRECTION_SELECT: biasDir_r <= rxShift_r;
        gex_pkg::OFS_IRQ_SOURCE_MASK: irqMask_r <= rxShift_r;
        gex_pkg::OFS_OUTPUT_STAGE_TYPE: stageOd_r <= rxShift_r[gex_pkg::STAGE_OPEN_DRAIN_BIT];
        // Sample, flags and unlisted codes: acknowledged, nothing stored
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Serial slave engine
  // ----------------------------------------------------------------
  logic addrMatch;
  // Upper six bits fixed, next bit from the pin
  assign addrMatch = (rxShift_r[7:2] == gex_pkg::SLV_ADDR_HI) && (rxShift_r[1] == addrSync_r[1]);

  assign wrStrobe = (state_r == gex_pkg::GEX_WDATA_ACK) && sclRise;
  // Clear point: acknowledge bit of a sample read, on the SCL rise
  assign sampleReadAck = (state_r == gex_pkg::GEX_RDATA_ACK) && sclRise
                         && (cmdTarget_r == gex_pkg::OFS_PIN_LEVEL_SAMPLE);

  // Byte framing, acknowledge and data phases
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= gex_pkg::GEX_IDLE;
      bitCnt_r <= 3'h0;
      rxShift_r <= 8'h00;
      txShift_r <= 8'h00;
      isRead_r <= 1'b0;
      byteDone_r <= 1'b0;
      cmdTarget_r <= gex_pkg::RST_POINTER;
      sdaOe <= 1'b0;
    end else if (startSeen) begin
      // Start or repeated start always restarts address phase
      state_r <= gex_pkg::GEX_ADDR;
      bitCnt_r <= 3'h0;
      byteDone_r <= 1'b0;
      sdaOe <= 1'b0;
    end else if (stopSeen) begin
      state_r <= gex_pkg::GEX_IDLE;
      sdaOe <= 1'b0;
    end else begin
      unique case (state_r)
        gex_pkg::GEX_IDLE: ;
        gex_pkg::GEX_ADDR, gex_pkg::GEX_CMD, gex_pkg::GEX_WDATA: begin
          if (sclRise) begin
            rxShift_r <= {rxShift_r[6:0], sdaSync_r[1]};
            bitCnt_r <= bitCnt_r + 3'h1;
            byteDone_r <= (bitCnt_r == 3'h7);
          end else if (sclFall && byteDone_r) begin
            // Falling edge after eighth bit opens acknowledge slot
            byteDone_r <= 1'b0;
            if (state_r == gex_pkg::GEX_ADDR) begin
              if (addrMatch) begin
                isRead_r <= rxShift_r[0];
                sdaOe <= 1'b1;
                state_r <= gex_pkg::GEX_ADDR_ACK;
              end else begin
                state_r <= gex_pkg::GEX_IDLE;             // Not ours
              end
            end else if (state_r == gex_pkg::GEX_CMD) begin
              cmdTarget_r <= rxShift_r;
              sdaOe <= 1'b1;
              state_r <= gex_pkg::GEX_CMD_ACK;
            end else begin
              sdaOe <= 1'b1;                              // Acknowledge every code
              state_r <= gex_pkg::GEX_WDATA_ACK;
            end
          end
        end
        gex_pkg::GEX_ADDR_ACK: begin
          if (sclFall) begin
            if (isRead_r) begin
              // Present first data bit straight after acknowledge
              txShift_r <= {rdByte[6:0], 1'b0};
              sdaOe <= ~rdByte[7];
              bitCnt_r <= 3'h0;
              state_r <= gex_pkg::GEX_RDATA;
            end else begin
              sdaOe <= 1'b0;
              bitCnt_r <= 3'h0;
              state_r <= gex_pkg::GEX_CMD;
            end
          end
        end
        gex_pkg::GEX_CMD_ACK, gex_pkg::GEX_WDATA_ACK: begin
          if (sclFall) begin
            sdaOe <= 1'b0;
            bitCnt_r <= 3'h0;
            state_r <= gex_pkg::GEX_WDATA;
          end
        end
        gex_pkg::GEX_RDATA: begin
          if (sclFall) begin
            bitCnt_r <= bitCnt_r + 3'h1;
            if (bitCnt_r == 3'h7) begin
              sdaOe <= 1'b0;                              // Release for master's acknowledge
              state_r <= gex_pkg::GEX_RDATA_ACK;
            end else begin
              sdaOe <= ~txShift_r[7];
              txShift_r <= {txShift_r[6:0], 1'b0};
            end
          end
        end
        gex_pkg::GEX_RDATA_ACK: begin
          if (sclRise) begin
            isRead_r <= ~sdaSync_r[1];                    // Low means master wants more
          end else if (sclFall) begin
            if (isRead_r) begin
              txShift_r <= {rdByte[6:0], 1'b0};
              sdaOe <= ~rdByte[7];
              bitCnt_r <= 3'h0;
              state_r <= gex_pkg::GEX_RDATA;
            end else begin
              state_r <= gex_pkg::GEX_IDLE;               // Not acknowledged: wait for stop
            end
          end
        end
      endcase
    end
  end

  // SDA only ever pulls low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Port and interrupt pin drivers
  // ----------------------------------------------------------------
  // Registered one cycle after the controlling registers change
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      portOut <= '0;
      portOe <= '0;
      driveLevel <= '1;
      biasEnable <= '0;
      biasPullUp <= '1;
      intOut <= 1'b0;
      intOe <= 1'b0;
    end else begin
      portOut <= driveValue_r;
      // Outputs only; open-drain never drives high
      portOe <= ~direction_r & ~(driveValue_r & {PORT_W{stageOd_r}});
      driveLevel <= {driveHi_r, driveLo_r};
      // Bias resistors drop out in open-drain mode
      biasEnable <= biasEn_r & {PORT_W{~stageOd_r}};
      biasPullUp <= biasDir_r;
      intOut <= 1'b0;
      intOe <= |srcFlags;
    end
  end

endmodule : gex_expander

// [verif/gex_expander_chk.sv]
// Checker: port timing of the expander, bound into gex_expander.
// Assumes a master with 8 ref_clk per bus bit.
module gex_expander_chk #(
  parameter int PORT_W = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic resetPinN,
  input wire logic sclPin,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [PORT_W-1:0] portIn,
  input wire logic [PORT_W-1:0] portOut,
  input wire logic [PORT_W-1:0] portOe,
  input wire logic [2*PORT_W-1:0] driveLevel,
  input wire logic [PORT_W-1:0] biasEnable,
  input wire logic [PORT_W-1:0] biasPullUp,
  input wire logic intOut,
  input wire logic intOe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Ages since reset, pin move and SCL rise
  // ----
  logic [3:0] quietAge; // Saturates; guards against reset ripple
  logic [3:0] pinAge;
  logic [3:0] sclAge;
  logic [PORT_W-1:0] pinPrev;
  logic sclPrev;
  // Saturating ages; reset keeps them defined from the start
  always_ff @(posedge ref_clk) begin
    pinPrev <= portIn;
    sclPrev <= sclPin;
    quietAge <= (sys_rst || !resetPinN) ? 4'h0 : quietAge + {3'h0, quietAge != 4'hf};
    if (sys_rst || portIn != pinPrev) begin
      pinAge <= 4'h0;
    end else if (pinAge != 4'hf) begin
      pinAge <= pinAge + 4'h1;
    end
    if (sys_rst || (sclPin && !sclPrev)) begin
      sclAge <= 4'h0;
    end else if (sclAge != 4'hf) begin
      sclAge <= sclAge + 4'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  rst_vals_a: assert property ($fell(sys_rst) |=> portOut == 8'hff && portOe == 8'h00 && driveLevel == 16'hffff)
    else $error("Outputs not at reset values");
  int_quiet_a: assert property ($fell(sys_rst) |=> !intOe [*8])
    else $error("Interrupt right after reset");
  ack_hold_a: assert property ($rose(sdaOe) |-> sdaOe [*6])
    else $error("SDA pull too short");
  od_lines_a: assert property (sdaOut == 1'b0 && intOut == 1'b0)
    else $error("Open-drain line driven high");
  port_upd_a: assert property (quietAge == 4'hf && ($changed(portOut) || $changed(portOe)) |-> sdaOe)
    else $error("Port drive changed outside a write");
  cfg_upd_a: assert property (quietAge == 4'hf && ($changed(driveLevel) || $changed(biasPullUp)) |-> sdaOe)
    else $error("Drive level changed outside a write");
  int_cause_a: assert property (quietAge == 4'hf && $rose(intOe) |-> (pinAge >= 4'h2 && pinAge <= 4'h8) || sdaOe)
    else $error("Interrupt rose without cause");
  int_clear_a: assert property (quietAge == 4'hf && $fell(intOe) |-> pinAge <= 4'h8 || sclAge <= 4'h8 || sdaOe)
    else $error("Interrupt fell without cause");
endmodule : gex_expander_chk
bind gex_expander gex_expander_chk #(.PORT_W(PORT_W)) gex_expander_chk_inst (.ref_clk, .sys_rst, .resetPinN,
  .sclPin, .sdaOut, .sdaOe, .portIn, .portOut, .portOe, .driveLevel, .biasEnable, .biasPullUp, .intOut, .intOe);

// [verif/gex_i2c_master.sv]
// Bus master model: drives SCL, pulls SDA low, reads SDA back.
// Assumes the bench resolves SDA with a pull-up.
module gex_i2c_master (
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sdaLow,
  output logic ackOk
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Bit and byte tasks
  // ----
  // SCL stands high between frames
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
    ackOk = 1'b0;
  end
  // Quarter bit of 40 ns, placed just after the core edge
  task automatic q();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : q
  // Start or repeated start: SDA falls while SCL is high
  task automatic go();
    // Let the slave release an acknowledge before SCL goes high
    q();
    sdaLow = 1'b0;
    q();
    scl = 1'b1;
    q();
    sdaLow = 1'b1;
    q();
    scl = 1'b0;
  endtask : go
  // Stop: SDA rises while SCL is high
  task automatic halt();
    sdaLow = 1'b1;
    q();
    scl = 1'b1;
    q();
    sdaLow = 1'b0;
    q();
    q();
  endtask : halt
  // SDA moves only with SCL low, so no false start or stop
  task automatic bit1(input logic b, output logic r);
    q();
    sdaLow = !b;
    q();
    scl = 1'b1;
    q();
    q();
    r = sda;
    scl = 1'b0;
  endtask : bit1
  // Byte MSB first, then the slave's acknowledge
  task automatic put(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit1(d[i], r);
    bit1(1'b1, r);
    ackOk = ackOk & !r;
  endtask : put
  // Read byte, then NACK to end the read
  task automatic get(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit1(1'b1, r);
      d[i] = r;
    end
    bit1(1'b1, r);
  endtask : get
  // Write: address with R/W low, command, one data byte
  task automatic wr(input logic a, input logic [7:0] cmd, input logic [7:0] d);
    ackOk = 1'b1;
    go();
    put({gex_pkg::SLV_ADDR_HI, a, 1'b0});
    put(cmd);
    put(d);
    halt();
  endtask : wr
  // Read: pointer set by a write, repeated start, address with R/W high
  task automatic rd(input logic a, input logic [7:0] cmd, output logic [7:0] d);
    ackOk = 1'b1;
    go();
    put({gex_pkg::SLV_ADDR_HI, a, 1'b0});
    put(cmd);
    go();
    put({gex_pkg::SLV_ADDR_HI, a, 1'b1});
    get(d);
    halt();
  endtask : rd
endmodule : gex_i2c_master

// [verif/gex_expander_tb_top.sv]
// Bench: register map, pin reads and interrupts over the serial bus.
// Assumes gex_i2c_master and the bound checker are compiled.
module gex_expander_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic resetPinN = 1'b1;
  logic addrSelPin = 1'b0;
  logic [7:0] extPins = 8'h00; // Level applied from outside
  logic scl, sdaLow, ackOk, sdaOut, sdaOe, intOut, intOe;
  logic [7:0] portOut, portOe, biasEnable, biasPullUp, rdv;
  logic [15:0] driveLevel;
  int err_count = 0;
  int comparisons = 0;
  // Pull-up SDA; a driven pin shows the device's own level
  wire logic sda = !(sdaLow || (sdaOe && !sdaOut));
  wire logic [7:0] portIn = (portOe & portOut) | (~portOe & extPins);
  always #10 ref_clk = ~ref_clk;
  gex_expander #(.PORT_W(8)) gex_expander_inst (.ref_clk, .sys_rst, .resetPinN, .addrSelPin, .sclPin(scl),
    .sdaIn(sda), .sdaOut, .sdaOe, .portIn, .portOut, .portOe, .driveLevel, .biasEnable, .biasPullUp,
    .intOut, .intOe);
  gex_i2c_master gex_i2c_master_inst (.ref_clk, .sda, .scl, .sdaLow, .ackOk);
  // ----
  // Helpers
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    gex_i2c_master_inst.wr(addrSelPin, c, d);
  endtask : wr
  task automatic rdc(input logic [7:0] c, input logic [7:0] e);
    gex_i2c_master_inst.rd(addrSelPin, c, rdv);
    chk({8'h00, rdv}, {8'h00, e});
  endtask : rdc
  // Change pins, then let sync and detection settle
  task automatic pins(input logic [7:0] v, input logic e);
    @(posedge ref_clk);
    #1 extPins = v;
    repeat (12) @(posedge ref_clk);
    chk({15'h0, intOe}, {15'h0, e});
  endtask : pins
  // ----
  // Scenarios
  // ----
  task automatic t_map();
    logic [7:0] ofs [10] = '{8'h01, 8'h02, 8'h03, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h4f};
    logic [7:0] rv [12] = '{8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h01, 8'h00, 8'h00};
    chk({portOut, portOe}, 16'hff00);
    for (int i = 0; i < 9; i++) rdc(ofs[i], rv[i]);
    rdc(8'h46, 8'h00);
    rdc(8'h4f, 8'h00);
    for (int i = 0; i < 10; i++) wr(ofs[i], 8'h96 ^ ofs[i]);
    for (int i = 0; i < 9; i++) rdc(ofs[i], 8'h96 ^ ofs[i]);
    rdc(8'h4f, rv[9]);
    chk({portOut, portOe}, 16'h9768);
    chk({biasEnable, biasPullUp}, 16'h00d2);
    wr(8'h40, 8'h1b);
    wr(8'h00, 8'h3c);
    wr(8'h07, 8'h11);
    chk(driveLevel, 16'hd71b);
    rdc(8'h07, 8'h00);
    rdc(8'h01, 8'h97);
  endtask : t_map
  // Wrong address bit is not acknowledged; then pin reset restores defaults
  task automatic t_addr_rst();
    gex_i2c_master_inst.wr(1'b1, 8'h01, 8'h00);
    chk({15'h0, ackOk}, 16'h0000);
    addrSelPin = 1'b1;
    rdc(8'h01, 8'h97);
    chk({15'h0, ackOk}, 16'h0001);
    @(posedge ref_clk);
    #1 resetPinN = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 resetPinN = 1'b1;
    repeat (8) @(posedge ref_clk);
    rdc(8'h42, 8'h00);
  endtask : t_addr_rst
  // Inversion on inputs only; outputs read their own level
  task automatic t_pins();
    wr(8'h02, 8'h0f);
    pins(8'h5a, 1'b0);
    rdc(8'h00, 8'h55);
    wr(8'h03, 8'hf0);
    rdc(8'h00, 8'h5f);
    wr(8'h03, 8'hff);
    rdc(8'h00, 8'h55);
    wr(8'h02, 8'h00);
    wr(8'h45, 8'h02);
    pins(8'h00, 1'b1);
    rdc(8'h00, 8'h00);
    pins(8'h01, 1'b1);
    pins(8'h00, 1'b0);
    pins(8'h02, 1'b0);
    pins(8'h00, 1'b0);
  endtask : t_pins
  // Latched pin 4 beside non-latched pin 0
  task automatic t_latch();
    wr(8'h42, 8'h10);
    pins(8'h10, 1'b1);
    pins(8'h00, 1'b1);
    rdc(8'h00, 8'h10);
    chk({15'h0, intOe}, 16'h0000);
    rdc(8'h00, 8'h00);
    pins(8'h11, 1'b1);
    pins(8'h00, 1'b1);
    rdc(8'h00, 8'h10);
    chk({15'h0, intOe}, 16'h0000);
    pins(8'h10, 1'b1);
    wr(8'h42, 8'h00);
    chk({15'h0, intOe}, 16'h0001);
    pins(8'h00, 1'b1);
    rdc(8'h00, 8'h00);
  endtask : t_latch
  task automatic give_verdict();
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  // Watchdog well beyond the roughly 16k cycles of the run
  initial begin
    #(80000 * 20);
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    repeat (6) @(posedge ref_clk);
    t_map();
    t_addr_rst();
    t_pins();
    t_latch();
    give_verdict();
  end
endmodule : gex_expander_tb_top
